// ### design/drsr_refresh.sv
`timescale 1ns/10ps
`include "drsr_defines.svh"
// What the document asks of this block and of its controller
// [R1] chip select, row and column strobes low, write high, cke high: start refresh
// [R2] controller refreshes only with all banks precharged for tRP
// [R3] refresh rows come from the internal counter, external address ignored
// [R4] after refresh every bank is left precharged and idle
// [R5] controller sends only nop or deselect during tRFC after refresh
// [R6] controller keeps average refresh spacing at tREFI
// [R7] controller defers at most 8 refreshes
// [R8] at most 8 early refreshes count against later ones
// [R9] at most 16 refreshes within two refresh intervals
// [R10] deferred and early counts stay frozen through self-refresh
// [R11] strobes and cke low, write high: enter self-refresh on internal timer
// [R12] controller enters self-refresh only from idle with timings met
// [R13] controller turns termination off before self-refresh entry
// [R14] controller holds cke low for the whole self-refresh stay
// [R15] dll enabled: disable on self-refresh entry, re-enable with reset on exit
// [R16] in self-refresh only cke and reset matter; clock gated; refresh within tCKE
// [R17] no write or leveling until 512 clocks after exit
// [R18] controller stays in self-refresh tCKESR and restarts clock before exit
// [R19] exit is cke high with nop; wait tXS, then tXSDLL for dll commands
// [R20] nop every edge during tXS; cke high and termination off in tXSDLL
// [R21] before re-entry wait tXS and give one extra refresh
// [R22] controller may calibrate after self-refresh
// [R23] controller tracks refresh debt from minus eight to plus eight
// [R24] controller holds cke low at least tCKE before raising it
module drsr_refresh #(
    parameter int ROW_W = 16,
    parameter int TREFI_CYC = `DRSR_TREFI_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cke_i,
    input wire logic cs_b_i,
    input wire logic ras_b_i,
    input wire logic cas_b_i,
    input wire logic we_b_i,
    input wire logic dll_off_i,
    output logic [ROW_W-1:0] refresh_row_o,
    output logic refresh_strobe_o,
    output logic refresh_busy_o,
    output logic banks_idle_o,
    output logic self_refresh_o,
    output logic clk_gate_en_o,
    output logic dll_enable_o,
    output logic dll_reset_o,
    output logic cmd_ignore_o
);

    // ----------------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------------
    // the row counter and its reset value are at most 16 bits wide
    if (ROW_W < 1 || ROW_W > 16) begin : g_row_w_check
        $error("ROW_W out of range");
    end
    // the interval timer is a 16-bit down counter
    if (TREFI_CYC < 2 || TREFI_CYC > 65535) begin : g_trefi_check
        $error("TREFI_CYC out of range");
    end

    localparam logic [15:0] TRFC_C = 16'(`DRSR_TRFC_CYC);
    localparam logic [15:0] TCKE_C = 16'(`DRSR_TCKE_CYC);
    localparam logic [15:0] TXS_C = 16'(`DRSR_TXS_CYC);
    localparam logic [15:0] TXSDLL_C = 16'(`DRSR_TXSDLL_NCK);
    localparam logic [15:0] TREFI_C = 16'(TREFI_CYC);

    // ----------------------------------------------------------------------
    // input synchronisers (pins, two flops before use)
    // ----------------------------------------------------------------------
    logic [5:0] pin_s1_reg;
    logic [5:0] pin_s2_reg;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_s1_reg <= 6'h3f;
            pin_s2_reg <= 6'h3f;
        end else begin
            pin_s1_reg <= {cke_i, cs_b_i, ras_b_i, cas_b_i, we_b_i, dll_off_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // ----------------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------------
    logic cke_reg;
    wire cke_s = pin_s2_reg[5];
    wire strobes_low = !pin_s2_reg[4] && !pin_s2_reg[3] && !pin_s2_reg[2] && pin_s2_reg[1];
    wire dll_off_s = pin_s2_reg[`DRSR_DLL_OFF_BIT];
    // cke was high last edge; now high keeps refresh, low means entry
    wire cmd_ref = strobes_low && cke_reg && cke_s; // [R1]
    wire cmd_sre = strobes_low && cke_reg && !cke_s; // [R11]
    // exit needs cke rising; command bus is don't care while in self-refresh
    wire cmd_srx = cke_s;

    // ----------------------------------------------------------------------
    // state and counters
    // ----------------------------------------------------------------------
    drsr_pkg::drsr_state_t state_reg;
    drsr_pkg::drsr_state_t state_next;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [15:0] timer_reg;
    logic [ROW_W-1:0] row_reg;
    logic strobe_reg;
    logic dll_was_on_reg;
    logic dll_en_reg;
    logic dll_rst_reg;

    wire cnt_done = (cnt_reg == 16'h0001);
    wire timer_tick = (timer_reg == 16'h0001);
    // a refresh is taken from idle and from the tail of the exit window alike
    wire ref_take = cmd_ref && (state_reg == drsr_pkg::DRSR_IDLE || state_reg == drsr_pkg::DRSR_EXIT_DLL);

    // next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next = (cnt_reg > 16'h0001) ? cnt_reg - 16'h0001 : cnt_reg;
        case (state_reg)
            drsr_pkg::DRSR_IDLE: begin
                if (cmd_ref) begin
                    state_next = drsr_pkg::DRSR_REFRESH;
                    cnt_next = TRFC_C;
                end else if (cmd_sre) begin
                    state_next = drsr_pkg::DRSR_SELF;
                    cnt_next = TCKE_C;
                end
            end
            drsr_pkg::DRSR_REFRESH: begin
                // the controller keeps the bus quiet for tRFC, so nothing is decoded
                if (cnt_done) state_next = drsr_pkg::DRSR_IDLE; // [R4] [R5]
            end
            drsr_pkg::DRSR_SELF: begin
                // cke must stay low at least tCKE before exit is honoured
                if (cmd_srx && cnt_done) begin // [R24] [R14]
                    state_next = drsr_pkg::DRSR_EXIT_XS;
                    cnt_next = TXS_C;
                end
            end
            drsr_pkg::DRSR_EXIT_XS: begin
                if (cnt_done) begin // [R19]
                    state_next = drsr_pkg::DRSR_EXIT_DLL;
                    cnt_next = TXSDLL_C - TXS_C;
                end
            end
            drsr_pkg::DRSR_EXIT_DLL: begin
                // the extra refresh before re-entry may land inside tXSDLL
                if (cnt_done) state_next = drsr_pkg::DRSR_IDLE; // [R17]
                else if (cmd_ref) begin
                    state_next = drsr_pkg::DRSR_REFRESH;
                    cnt_next = TRFC_C;
                end
            end
            default: begin
                state_next = drsr_pkg::DRSR_IDLE;
            end
        endcase
    end

    // state register, refresh row counter and dll control
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= drsr_pkg::DRSR_IDLE;
            cnt_reg <= 16'h0000;
            cke_reg <= 1'b0;
            row_reg <= ROW_W'(`DRSR_ROW_RST);
            strobe_reg <= 1'b0;
            timer_reg <= 16'h0000;
            dll_was_on_reg <= 1'b0;
            dll_en_reg <= 1'b0;
            dll_rst_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cke_reg <= cke_s;
            strobe_reg <= 1'b0;
            dll_rst_reg <= 1'b0;
            // external refresh: row from internal counter only
            if (ref_take) begin
                row_reg <= row_reg + ROW_W'(1); // [R3]
                strobe_reg <= 1'b1;
            end
            // internal timer; first refresh fires right at entry, inside tCKE
            if (state_reg == drsr_pkg::DRSR_IDLE && cmd_sre) begin
                timer_reg <= TREFI_C; // [R16]
                row_reg <= row_reg + ROW_W'(1);
                strobe_reg <= 1'b1;
                dll_was_on_reg <= !dll_off_s;
                if (!dll_off_s) dll_en_reg <= 1'b0; // [R15]
            end else if (state_reg == drsr_pkg::DRSR_SELF) begin
                timer_reg <= timer_tick ? TREFI_C : timer_reg - 16'h0001;
                if (timer_tick) begin
                    row_reg <= row_reg + ROW_W'(1);
                    strobe_reg <= 1'b1;
                end
                // relock the dll on exit, with a reset pulse
                if (state_next == drsr_pkg::DRSR_EXIT_XS && dll_was_on_reg) begin
                    dll_en_reg <= 1'b1; // [R15]
                    dll_rst_reg <= 1'b1;
                end
            end else if (state_reg == drsr_pkg::DRSR_IDLE) begin
                dll_en_reg <= !dll_off_s;
            end
        end
    end

    // ----------------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------------
    // clock stays gated through self-refresh; the internal refresh timer and exit detection there still count clk_i edges
    wire in_self = (state_reg == drsr_pkg::DRSR_SELF);
    assign refresh_row_o = row_reg;
    assign refresh_strobe_o = strobe_reg;
    assign refresh_busy_o = (state_reg == drsr_pkg::DRSR_REFRESH);
    assign banks_idle_o = !refresh_busy_o; // [R4]
    assign self_refresh_o = in_self;
    assign clk_gate_en_o = !in_self; // [R16]
    assign cmd_ignore_o = in_self || (state_reg == drsr_pkg::DRSR_EXIT_XS); // [R16]
    assign dll_enable_o = dll_en_reg;
    assign dll_reset_o = dll_rst_reg;

endmodule

// ### design/drsr_defines.svh
`ifndef DRSR_DEFINES_SVH
`define DRSR_DEFINES_SVH

// --------------------------------------------------------------------------
// timing (40 MHz clock, 25 ns period)
// --------------------------------------------------------------------------
`define DRSR_CLK_PERIOD_PS 25000
`define DRSR_TRFC_NS 110
`define DRSR_TCKE_NS 5
`define DRSR_TREFI_NS 7800
`define DRSR_TXS_NS 120
`define DRSR_TXSDLL_NCK 512
// least times round up, none below one cycle
`define DRSR_CYC_UP(ns) ((((ns) * 1000 + `DRSR_CLK_PERIOD_PS - 1) / `DRSR_CLK_PERIOD_PS) < 1 ? 1 : \
    (((ns) * 1000 + `DRSR_CLK_PERIOD_PS - 1) / `DRSR_CLK_PERIOD_PS))
`define DRSR_TRFC_CYC `DRSR_CYC_UP(`DRSR_TRFC_NS)
`define DRSR_TCKE_CYC `DRSR_CYC_UP(`DRSR_TCKE_NS)
`define DRSR_TREFI_CYC `DRSR_CYC_UP(`DRSR_TREFI_NS)
`define DRSR_TXS_CYC `DRSR_CYC_UP(`DRSR_TXS_NS)

// --------------------------------------------------------------------------
// field positions and reset values
// --------------------------------------------------------------------------
`define DRSR_DLL_OFF_BIT 0
`define DRSR_ROW_RST 16'h0000

`endif

// ### design/drsr_pkg.sv
package drsr_pkg;
    typedef enum logic [2:0] {
        DRSR_IDLE,
        DRSR_REFRESH,
        DRSR_SELF,
        DRSR_EXIT_XS,
        DRSR_EXIT_DLL
    } drsr_state_t;
endpackage

// ### testbench/drsr_refresh_properties.sv
`timescale 1ns/10ps
// ----------------
// port checks
// ----------------
module drsr_refresh_checker #(
    parameter int ROW_W = 16,
    parameter int TREFI_CYC = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cke_i,
    input wire logic cs_b_i,
    input wire logic ras_b_i,
    input wire logic cas_b_i,
    input wire logic we_b_i,
    input wire logic dll_off_i,
    input wire logic [ROW_W-1:0] refresh_row_o,
    input wire logic refresh_strobe_o,
    input wire logic refresh_busy_o,
    input wire logic banks_idle_o,
    input wire logic self_refresh_o,
    input wire logic clk_gate_en_o,
    input wire logic dll_enable_o,
    input wire logic dll_reset_o,
    input wire logic cmd_ignore_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // a command shape that the idle device must take
    wire cmd_ok = !cs_b_i && !ras_b_i && !cas_b_i && we_b_i && banks_idle_o && !cmd_ignore_o && !self_refresh_o;
    property p_ref; cmd_ok && cke_i && $past(cke_i) |-> ##[2:4] refresh_strobe_o; endproperty
    a_ref: assert property (p_ref) else $error("refresh not started");
    property p_sre; cmd_ok && !cke_i && $past(cke_i) |-> ##[2:4] self_refresh_o; endproperty
    a_sre: assert property (p_sre) else $error("self refresh not entered");
    property p_pulse; refresh_strobe_o |=> !refresh_strobe_o; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe longer than one cycle");
    property p_row; refresh_strobe_o |-> refresh_row_o == ROW_W'($past(refresh_row_o) + 1); endproperty
    a_row: assert property (p_row) else $error("row not advanced");
    property p_idle; banks_idle_o == !refresh_busy_o; endproperty
    a_idle: assert property (p_idle) else $error("idle flag wrong");
    property p_busy; $rose(refresh_busy_o) |-> refresh_busy_o[*5] ##1 !refresh_busy_o; endproperty
    a_busy: assert property (p_busy) else $error("busy length wrong");
    property p_sr_ref; $rose(self_refresh_o) |-> ##[0:2] refresh_strobe_o; endproperty
    a_sr_ref: assert property (p_sr_ref) else $error("no refresh on entry");
    property p_gate; self_refresh_o |-> !clk_gate_en_o && cmd_ignore_o; endproperty
    a_gate: assert property (p_gate) else $error("clock or inputs live in self refresh");
    property p_dll_off; self_refresh_o |-> !dll_enable_o; endproperty
    a_dll_off: assert property (p_dll_off) else $error("dll on in self refresh");
    property p_dll_rst; $fell(self_refresh_o) && !dll_off_i |-> ##[0:3] dll_reset_o; endproperty
    a_dll_rst: assert property (p_dll_rst) else $error("no dll reset on exit");
    // the exit window is exactly tXS, five cycles at this clock
    property p_xs; $fell(self_refresh_o) |-> cmd_ignore_o[*5] ##1 !cmd_ignore_o; endproperty
    a_xs: assert property (p_xs) else $error("exit window wrong");
    c_ref: cover property (refresh_busy_o);
    c_self: cover property ($fell(self_refresh_o));
    c_dll: cover property (dll_reset_o);
endmodule
bind drsr_refresh drsr_refresh_checker #(.ROW_W(ROW_W), .TREFI_CYC(TREFI_CYC)) i_drsr_refresh_checker (.*);

// ### testbench/drsr_ctrl_model.sv
`timescale 1ns/10ps
// ----------------
// controller pins: 0 deselect, 1 nop, 2 ref or entry
// ----------------
module drsr_ctrl_model (
    input wire logic clk_i,
    input wire logic [1:0] cmd_i,
    input wire logic cke_i,
    output logic cke_o,
    output logic cs_b_o,
    output logic ras_b_o,
    output logic cas_b_o,
    output logic we_b_o
);
    logic wob = 1'b0;
    // deselected lines toggle, so a stale level never decodes
    always @(negedge clk_i) wob <= ~wob;
    assign cke_o = cke_i;
    // only deselect, nop and refresh or entry exist: no write, leveling or calibration
    assign cs_b_o = (cmd_i == 2'h0);
    assign ras_b_o = cmd_i[1] ? 1'b0 : (cs_b_o ? wob : 1'b1);
    assign cas_b_o = cmd_i[1] ? 1'b0 : (cs_b_o ? wob : 1'b1);
    assign we_b_o = cmd_i[1] ? 1'b1 : (cs_b_o ? ~wob : 1'b1);
endmodule

// ### testbench/drsr_refresh_test.sv
`timescale 1ns/10ps
module drsr_refresh_test;
    localparam int TREFI = 8;
    logic clk, rst_b, cke, dll_off, kp, cs, ras, cas, we, stb, busy, idle, sr, gate, dll, drst, ign, hit, in_sr;
    logic [1:0] cmd;
    logic [15:0] row;
    int err_total = 0, comparisons = 0, exp_row = 0, cnt, stay, k;
    int debt = 0, tick = 0, cyc = 0, held;
    int refq[$];
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    drsr_ctrl_model i_drsr_ctrl_model (.clk_i(clk), .cmd_i(cmd), .cke_i(cke), .cke_o(kp), .cs_b_o(cs),
        .ras_b_o(ras), .cas_b_o(cas), .we_b_o(we));
    drsr_refresh #(.TREFI_CYC(TREFI)) i_drsr_refresh (.clk_i(clk), .rst_b_i(rst_b), .cke_i(kp), .cs_b_i(cs),
        .ras_b_i(ras), .cas_b_i(cas), .we_b_i(we), .dll_off_i(dll_off), .refresh_row_o(row),
        .refresh_strobe_o(stb), .refresh_busy_o(busy), .banks_idle_o(idle), .self_refresh_o(sr),
        .clk_gate_en_o(gate), .dll_enable_o(dll), .dll_reset_o(drst), .cmd_ignore_o(ign));
    // ----------------
    // helpers
    // ----------------
    // self-refresh strobes and dll reset pulses are caught on the way
    // counted until the exit window closes, so a strobe on the exit edge is not lost
    always @(negedge clk) begin
        if (in_sr && stb) cnt++;
        if (drst) hit = 1'b1;
    end
    // refresh debt model: one owed per interval, frozen while self-refreshing
    always @(posedge clk) begin
        if (rst_b) begin
            cyc++;
            if (!in_sr) tick++;
            if (tick == TREFI) begin
                tick = 0;
                debt++;
            end
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("counts: %0d compared, %0d failed", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic drive(input logic [1:0] c, input logic ck, input int n);
        repeat (n) begin
            @(negedge clk);
            cmd = c;
            cke = ck;
        end
    endtask
    // bounded wait: 0 strobe, 1 self, 2 busy, 3 ignore
    task automatic await(input int s, input logic lvl);
        for (k = 0; k < 12 && (s == 0 ? stb : s == 1 ? sr : s == 2 ? busy : ign) !== lvl; k++) drive(cmd, cke, 1);
        if (k == 12) begin
            err_total++;
            close_out();
        end
    endtask
    task automatic one_ref();
        drive(2'h2, 1'b1, 1);
        debt--;
        refq.push_back(cyc);
        while (refq.size() > 0 && cyc - refq[0] >= 2 * TREFI) refq.pop_front();
        check(refq.size() <= 16, 1'b1);
        check(debt >= -8 && debt <= 8, 1'b1);
        drive(2'h1, 1'b1, 1);
        await(0, 1'b1);
        exp_row++;
        check(row, exp_row[15:0]);
    endtask
    // ----------------
    // main sequence
    // ----------------
    initial begin
        void'($urandom(32'hd3b0322e));
        {rst_b, cmd, cke, dll_off, hit, cnt, in_sr} = '0;
        repeat (10) @(posedge clk);
        check({row[3:0], idle, gate, sr, dll, ign, busy, stb}, 16'h0060);
        @(negedge clk) rst_b = 1'b1;
        cke = 1'b1;
        drive(2'h0, 1'b1, 4);
        repeat ($urandom_range(4, 2)) begin
            one_ref();
            check({busy, idle}, 16'h2);
            drive(2'h2, 1'b1, 1); // refused while busy
            drive(2'h1, 1'b1, 1);
            await(2, 1'b0);
            check({busy, idle, row}, {2'b01, exp_row[15:0]});
        end
        $display("test refresh done");
        for (int d = 0; d < 2; d++) begin
            dll_off = d[0];
            drive(2'h1, 1'b1, 4);
            check(dll, !dll_off);
            {cnt, hit} = '0;
            in_sr = 1'b1;
            held = debt;
            drive(2'h2, 1'b0, 1);
            await(1, 1'b1);
            check({gate, ign, dll}, 3'b010);
            stay = $urandom_range(40, 20);
            repeat (stay) drive(2'($urandom_range(2, 0)), 1'b0, 1);
            drive(2'h1, 1'b1, 1);
            await(1, 1'b0);
            check(ign, 1'b1);
            drive(2'h2, 1'b1, 1); // refused in exit window
            drive(2'h1, 1'b1, 1);
            await(3, 1'b0);
            in_sr = 1'b0;
            check(debt, held);
            check(cnt >= stay / 8 && cnt <= stay / 8 + 3, 1'b1);
            exp_row += cnt;
            check({hit, dll, gate, row}, {~dll_off, ~dll_off, 1'b1, exp_row[15:0]});
            one_ref();
            await(2, 1'b0);
            $display("test self refresh %0d done", d);
        end
        close_out();
    end
endmodule
